// [hw/adcsq_ctrl.sv]
// Contract
// RQ1: push result as low byte, then high
// RQ2: host reads low offset, then high offset
// RQ3: scan converts every channel low to high
// RQ4: single mode: one conversion, advance, idle
// RQ5: irq enabled: interrupt at sample threshold
// RQ6: irq disabled: no interrupt, fifo fills
// RQ7: full fifo: set overflow, drop result
// RQ8: overflow cleared by fifo clear or reset
// RQ9: host sets threshold as scan multiple
// RQ10: irq off: low-offset write triggers conversion
// RQ11: busy high through whole scan
// RQ12: irq on: only selected source triggers
// RQ13: service routine reads threshold samples
// RQ14: threshold, irq enable, scan bit positions
// RQ15: busy bit seven; channel limit nibbles
// RQ16: busy one converting, zero when done
// RQ17: pointer wraps from high to low limit
// RQ18: empty read undefined, no underflow
// RQ19: threshold counts samples; irq is level
// RQ20: reset empties fifo, clears flags, pointer
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module adcsq_ctrl
  import adcsq_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  output logic [7:0] o_rd_data,
  input wire logic i_counter_tick,
  input wire logic i_ext_trigger,
  output adcsq_conv_req_t o_conv,
  input wire adcsq_conv_res_t i_conv,
  output logic o_busy,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  adcsq_state_t state;
  logic [7:0] chan_reg;
  logic [2:0] stat_reg;
  logic [7:0] ctrl_reg;
  logic [5:0] thresh;
  logic [3:0] chan_ptr;
  logic scan_run;
  logic fifo_overflow_flag;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic [CNT_W-1:0] fifo_bytes;
  logic [7:0] fifo_head;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic wr_lo;
  logic wr_hi;
  logic wr_chan;
  logic wr_stat;
  logic wr_ctrl;
  logic wr_thresh;
  logic pop;
  logic fifo_clear;
  logic converter_irq_enable;
  logic trigger_source_select;
  logic scan_enable_bit;
  logic [3:0] chan_low;
  logic [3:0] chan_high;
  logic ext_rise;
  logic sw_trig;
  logic hw_trig;
  logic trigger;
  logic conv_done;
  logic last_chan;
  logic fifo_full;
  logic push;
  logic ovf_set;
  logic [5:0] samples;
  logic irq_level;
  logic [3:0] next_ptr;
  logic [7:0] rd_value;

  assign wr_lo = i_wr_stb && (i_addr == ADDR_DATA_LO);
  assign wr_hi = i_wr_stb && (i_addr == ADDR_DATA_HI);
  assign wr_chan = i_wr_stb && (i_addr == ADDR_CHAN);
  assign wr_stat = i_wr_stb && (i_addr == ADDR_STATUS);
  assign wr_ctrl = i_wr_stb && (i_addr == ADDR_CTRL);
  assign wr_thresh = i_wr_stb && (i_addr == ADDR_THRESH);
  assign pop = i_rd_stb
               && ((i_addr == ADDR_DATA_LO) || (i_addr == ADDR_DATA_HI));
  assign fifo_clear = wr_hi && i_wr_data[CLEAR_BIT]; // RQ8

  assign converter_irq_enable = ctrl_reg[IRQEN_BIT]; // RQ14
  assign trigger_source_select = ctrl_reg[TRIGSEL_BIT];
  assign scan_enable_bit = stat_reg[SCAN_BIT]; // RQ14
  assign chan_low = chan_reg[CHAN_LO_POS +: 4]; // RQ15
  assign chan_high = chan_reg[CHAN_HI_POS +: 4]; // RQ15

  // ----------------------------------------------------------------
  // trigger selection
  // ----------------------------------------------------------------
  assign ext_rise = ext_sync && !ext_prev;
  assign sw_trig = wr_lo && !converter_irq_enable; // RQ10
  assign hw_trig = converter_irq_enable
                   && (trigger_source_select ? ext_rise : i_counter_tick); // RQ12
  assign trigger = sw_trig || hw_trig;

  // ----------------------------------------------------------------
  // conversion completion
  // ----------------------------------------------------------------
  assign conv_done = (state == ST_WAIT) && i_conv.done;
  assign last_chan = (chan_ptr == chan_high);
  assign next_ptr = last_chan ? chan_low : chan_ptr + 4'h1; // RQ17
  assign fifo_full = (fifo_bytes > FIFO_PUSH_MAX);
  assign push = conv_done && !fifo_full && !fifo_overflow_flag; // RQ7
  assign ovf_set = conv_done && fifo_full; // RQ7
  assign samples = fifo_bytes[CNT_W-1:1]; // RQ19
  assign irq_level = converter_irq_enable && (samples >= thresh); // RQ5 RQ6

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  assign rd_value =
    (i_addr == ADDR_DATA_LO || i_addr == ADDR_DATA_HI) ? fifo_head :
    (i_addr == ADDR_CHAN) ? chan_reg :
    (i_addr == ADDR_STATUS) ? {o_busy, fifo_overflow_flag, 3'h0,
                               stat_reg} : // RQ15
    (i_addr == ADDR_CTRL) ? ctrl_reg :
    (i_addr == ADDR_THRESH) ? {2'h0, thresh} :
    (i_addr == ADDR_COUNT) ? {2'h0, samples} : 8'h00;

  // ----------------------------------------------------------------
  // fifo
  // ----------------------------------------------------------------
  adcsq_fifo u_fifo (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_clear(fifo_clear),
    .i_push(push),
    .i_sample(i_conv.data),
    .i_pop(pop),
    .o_head(fifo_head),
    .o_bytes(fifo_bytes)
  );

  // ----------------------------------------------------------------
  // external trigger synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= i_ext_trigger;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      chan_reg <= CHAN_RST;
      stat_reg <= STAT_RST;
      ctrl_reg <= CTRL_RST;
      thresh <= THRESH_RST;
      o_rd_data <= 8'h00;
    end else begin
      if (wr_chan) begin
        chan_reg <= i_wr_data;
      end
      if (wr_stat) begin
        stat_reg <= i_wr_data[2:0];
      end
      if (wr_ctrl) begin
        ctrl_reg <= i_wr_data;
      end
      if (wr_thresh) begin
        thresh <= i_wr_data[THRESH_W-1:0]; // RQ14
      end
      o_rd_data <= i_rd_stb ? rd_value : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // overflow flag and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      fifo_overflow_flag <= 1'b0; // RQ20
      o_irq <= 1'b0;
    end else begin
      if (ovf_set) begin
        fifo_overflow_flag <= 1'b1; // RQ7
      end else if (fifo_clear) begin
        fifo_overflow_flag <= 1'b0; // RQ8
      end
      o_irq <= irq_level; // RQ19
    end
  end

  // ----------------------------------------------------------------
  // channel pointer
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      chan_ptr <= CHAN_RST[CHAN_LO_POS +: 4]; // RQ20
    end else if (wr_chan) begin
      chan_ptr <= i_wr_data[CHAN_LO_POS +: 4];
    end else if (state == ST_IDLE && trigger && scan_enable_bit) begin
      chan_ptr <= chan_low; // RQ3
    end else if (conv_done) begin
      chan_ptr <= next_ptr; // RQ4 RQ17
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state <= ST_IDLE;
      o_busy <= 1'b0; // RQ20
      scan_run <= 1'b0;
      o_conv <= '0;
    end else begin
      o_conv.start <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (trigger) begin
            state <= ST_START;
            o_busy <= 1'b1; // RQ16
            scan_run <= scan_enable_bit;
          end
        end
        ST_START: begin
          o_conv.start <= 1'b1;
          o_conv.channel <= chan_ptr;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (i_conv.done) begin
            if (scan_run && !last_chan) begin
              state <= ST_START; // RQ3 RQ11
            end else begin
              state <= ST_IDLE; // RQ4
              o_busy <= 1'b0; // RQ16
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          o_busy <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sw_trigger_start: assert property ( // RQ10
    @(posedge i_core_clk) disable iff (i_reset)
    (sw_trig && state == ST_IDLE) |=> o_busy ##1 (o_conv.start && o_busy))
    else $error("software trigger did not start a conversion");

  a_hw_only_trigger: assert property ( // RQ12
    @(posedge i_core_clk) disable iff (i_reset)
    (state == ST_IDLE && converter_irq_enable && !hw_trig) |=> !o_busy)
    else $error("conversion started without selected trigger");

  a_overflow_set: assert property ( // RQ7
    @(posedge i_core_clk) disable iff (i_reset)
    (ovf_set && !fifo_clear) |=> (fifo_overflow_flag
                 && fifo_bytes == $past(fifo_bytes)
                 - (($past(pop) && $past(fifo_bytes) != 7'h00) ? 7'h01 : 7'h00)))
    else $error("overflow not flagged or fifo changed");

  a_overflow_hold: assert property ( // RQ8
    @(posedge i_core_clk) disable iff (i_reset)
    (fifo_overflow_flag && !fifo_clear) |=> fifo_overflow_flag)
    else $error("overflow dropped without fifo clear");

  a_overflow_clear: assert property ( // RQ8
    @(posedge i_core_clk) disable iff (i_reset)
    (fifo_clear && !ovf_set) |=> (!fifo_overflow_flag && fifo_bytes == 7'h00))
    else $error("fifo clear did not empty fifo");

  a_push_pair: assert property ( // RQ1
    @(posedge i_core_clk) disable iff (i_reset)
    (push && !pop && !fifo_clear) |=> fifo_bytes == $past(fifo_bytes) + 7'h02)
    else $error("sample not stored as two bytes");

  a_irq_off: assert property ( // RQ6
    @(posedge i_core_clk) disable iff (i_reset)
    !converter_irq_enable |=> !o_irq)
    else $error("interrupt raised while disabled");

  a_irq_threshold: assert property ( // RQ5
    @(posedge i_core_clk) disable iff (i_reset)
    (converter_irq_enable && samples >= thresh) |=> o_irq)
    else $error("interrupt missing at threshold");

  a_scan_busy: assert property ( // RQ11
    @(posedge i_core_clk) disable iff (i_reset)
    (conv_done && scan_run && !last_chan) |=> (o_busy && state == ST_START)
      ##1 (o_busy && o_conv.start))
    else $error("scan stopped before last channel");

  a_single_done: assert property ( // RQ4
    @(posedge i_core_clk) disable iff (i_reset)
    (conv_done && !scan_run) |=> (!o_busy && state == ST_IDLE))
    else $error("single conversion did not end");

  a_pointer_wrap: assert property ( // RQ17
    @(posedge i_core_clk) disable iff (i_reset)
    (conv_done && last_chan && !wr_chan) |=> chan_ptr == $past(chan_low))
    else $error("channel pointer did not wrap");

endmodule
`default_nettype wire

// [hw/adcsq_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module adcsq_fifo
  import adcsq_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clear,
  input wire logic i_push,
  input wire logic [15:0] i_sample,
  input wire logic i_pop,
  output logic [7:0] o_head,
  output logic [CNT_W-1:0] o_bytes
);

  // ----------------------------------------------------------------
  // byte storage and pointers
  // ----------------------------------------------------------------
  logic [7:0] mem [96];
  logic [CNT_W-1:0] wr_ptr;
  logic [CNT_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] wr_second;
  logic can_push;
  logic can_pop;

  function automatic logic [CNT_W-1:0] ptr_inc(input logic [CNT_W-1:0] p);
    return (p == FIFO_LAST) ? '0 : p + 7'h01;
  endfunction

  assign can_push = i_push && (count <= FIFO_PUSH_MAX);
  assign can_pop = i_pop && (count != '0); // RQ18
  assign wr_second = ptr_inc(wr_ptr);
  assign next_count = count + (can_push ? FIFO_STEP_PUSH : 7'h00)
                      - (can_pop ? FIFO_STEP_POP : 7'h00);
  assign o_head = mem[rd_ptr];
  assign o_bytes = count;

  // low byte first, high byte next
  always_ff @(posedge i_core_clk) begin
    if (can_push) begin
      mem[wr_ptr] <= i_sample[7:0]; // RQ1
      mem[wr_second] <= i_sample[15:8]; // RQ1
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset || i_clear) begin // RQ8 RQ20
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (can_push) begin
        wr_ptr <= ptr_inc(wr_second);
      end
      if (can_pop) begin
        rd_ptr <= ptr_inc(rd_ptr);
      end
      count <= next_count;
    end
  end

endmodule
`default_nettype wire

// [shared/adcsq_pkg.sv]
`default_nettype none
package adcsq_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_DATA_LO = 4'h0;
  localparam logic [3:0] ADDR_DATA_HI = 4'h1;
  localparam logic [3:0] ADDR_CHAN = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_THRESH = 4'h5;
  localparam logic [3:0] ADDR_COUNT = 4'hC;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BUSY_BIT = 7;
  localparam int OVF_BIT = 6;
  localparam int SCAN_BIT = 2;
  localparam int IRQEN_BIT = 0;
  localparam int TRIGSEL_BIT = 4;
  localparam int CLEAR_BIT = 0;
  localparam int CHAN_LO_POS = 0;
  localparam int CHAN_HI_POS = 4;
  localparam int THRESH_W = 6;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] CHAN_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] STAT_RST = 3'h0;
  localparam logic [5:0] THRESH_RST = 6'h00;

  // ----------------------------------------------------------------
  // fifo sizing, in bytes
  // ----------------------------------------------------------------
  localparam int CNT_W = 7;
  localparam logic [6:0] FIFO_LAST = 7'h5F;
  localparam logic [6:0] FIFO_PUSH_MAX = 7'h5E;
  localparam logic [6:0] FIFO_STEP_PUSH = 7'h02;
  localparam logic [6:0] FIFO_STEP_POP = 7'h01;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_START = 3'b010,
    ST_WAIT = 3'b100
  } adcsq_state_t;

  typedef struct packed {
    logic start;
    logic [3:0] channel;
  } adcsq_conv_req_t;

  typedef struct packed {
    logic done;
    logic [15:0] data;
  } adcsq_conv_res_t;

endpackage
`default_nettype wire

// [verification/adcsq_conv_model.sv]
`timescale 1ns/1ps
`default_nettype none
module adcsq_conv_model
  import adcsq_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire adcsq_conv_req_t i_req,
  output adcsq_conv_res_t o_res
);
  // ----------------------------------------------------------------
  // converter: alternates quick and slow answers
  // ----------------------------------------------------------------
  logic [3:0] wait_cnt;
  logic [3:0] chan;
  logic pending;
  logic slow;
  always_ff @(posedge i_core_clk) begin
    o_res.done <= 1'b0;
    o_res.data <= ~o_res.data;
    if (i_reset) begin
      pending <= 1'b0;
      slow <= 1'b0;
      o_res.data <= 16'h0000;
    end else if (i_req.start) begin
      pending <= 1'b1;
      chan <= i_req.channel;
      wait_cnt <= slow ? 4'h6 : 4'h0;
      slow <= ~slow;
    end else if (pending && wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else if (pending) begin
      pending <= 1'b0;
      o_res.done <= 1'b1;
      o_res.data <= {4'hA, chan, 4'h5, chan};
    end
  end
endmodule
`default_nettype wire

// [verification/tb_adc_scan_fifo_irq_control.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_adc_scan_fifo_irq_control;
  import adcsq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic tick = 1'b0;
  logic ext = 1'b0;
  logic [7:0] rdata;
  logic busy;
  logic irq;
  adcsq_conv_req_t req;
  adcsq_conv_res_t res;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;

  adcsq_ctrl u_dut (.i_core_clk(clk), .i_reset(rst), .i_addr(addr),
    .i_wr_data(wdata), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb),
    .o_rd_data(rdata), .i_counter_tick(tick), .i_ext_trigger(ext),
    .o_conv(req), .i_conv(res), .o_busy(busy), .o_irq(irq));
  adcsq_conv_model u_conv (.i_core_clk(clk), .i_reset(rst), .i_req(req),
    .o_res(res));

  // ----------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count = fail_count + 1;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic rd_sample(input logic [3:0] ch);
    rd(ADDR_DATA_LO, {4'h5, ch});
    rd(ADDR_DATA_HI, {4'hA, ch});
  endtask
  task automatic wait_idle(input int dones);
    int n;
    int k;
    n = 0;
    k = 0;
    while (busy !== 1'b1 && k < 10) begin
      @(posedge clk);
      #1;
      k = k + 1;
    end
    chk({7'h00, busy}, 8'h01);
    k = 0;
    while (busy === 1'b1 && k < 2000) begin
      @(posedge clk);
      #1;
      if (res.done === 1'b1) n = n + 1;
      k = k + 1;
    end
    chk(n[7:0], dones[7:0]);
    chk({7'h00, busy}, 8'h00);
  endtask
  task automatic pulse_tick();
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    rd(ADDR_CHAN, CHAN_RST);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_THRESH, 8'h00);
    rd(ADDR_COUNT, 8'h00);
    rd(4'h7, 8'h00);
    chk({6'h00, busy, irq}, 8'h00);
  endtask
  task automatic t_single();
    wr(ADDR_CHAN, 8'h20);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_DATA_LO, 8'h00);
      wait_idle(1);
      rd(ADDR_COUNT, 8'h01);
      rd_sample(4'(i % 3));
    end
    chk({7'h00, irq}, 8'h00);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= ADDR_DATA_LO;
    @(posedge clk);
    rd_stb <= 1'b0;
    rd(ADDR_COUNT, 8'h00);
  endtask
  task automatic t_scan();
    wr(ADDR_STATUS, 8'h04);
    rd(ADDR_STATUS, 8'h04);
    wr(ADDR_DATA_LO, 8'h00);
    wait_idle(3);
    rd(ADDR_COUNT, 8'h03);
    for (int i = 0; i < 3; i++) rd_sample(4'(i));
    wr(ADDR_STATUS, 8'h00);
  endtask
  task automatic t_irq();
    wr(ADDR_CHAN, 8'h10);
    wr(ADDR_THRESH, 8'h02);
    wr(ADDR_CTRL, 8'h01);
    rd(ADDR_CTRL, 8'h01);
    wr(ADDR_DATA_LO, 8'h00);
    repeat (20) @(posedge clk);
    rd(ADDR_COUNT, 8'h00);
    pulse_tick();
    wait_idle(1);
    repeat (3) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    pulse_tick();
    wait_idle(1);
    repeat (3) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    wr(ADDR_CTRL, 8'h11);
    pulse_tick();
    repeat (20) @(posedge clk);
    rd(ADDR_COUNT, 8'h02);
    @(posedge clk);
    ext <= 1'b1;
    repeat (4) @(posedge clk);
    ext <= 1'b0;
    wait_idle(1);
    chk({7'h00, irq}, 8'h01);
    wr(ADDR_CTRL, 8'h10);
    repeat (3) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    rd(ADDR_COUNT, 8'h03);
    for (int i = 0; i < 3; i++) rd_sample(4'(i % 2));
  endtask
  task automatic t_overflow();
    wr(ADDR_CHAN, 8'hF0);
    wr(ADDR_STATUS, 8'h04);
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_DATA_LO, 8'h00);
      wait_idle(16);
    end
    rd(ADDR_COUNT, 8'h30);
    rd(ADDR_STATUS, 8'h04);
    wr(ADDR_DATA_LO, 8'h00);
    wait_idle(16);
    rd(ADDR_STATUS, 8'h44);
    rd(ADDR_COUNT, 8'h30);
    rd_sample(4'h0);
    rd(ADDR_COUNT, 8'h2F);
    rd(ADDR_STATUS, 8'h44);
    wr(ADDR_DATA_HI, 8'h01);
    rd(ADDR_COUNT, 8'h00);
    rd(ADDR_STATUS, 8'h04);
  endtask
  task automatic t_irq_scan();
    wr(ADDR_CHAN, 8'h10);
    wr(ADDR_STATUS, 8'h04);
    wr(ADDR_THRESH, 8'h02);
    wr(ADDR_CTRL, 8'h01);
    pulse_tick();
    wait_idle(2);
    repeat (3) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    for (int i = 0; i < 2; i++) rd_sample(4'(i));
    repeat (3) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    wr(ADDR_CTRL, 8'h00);
  endtask
  task automatic t_hw_reset();
    wr(ADDR_CHAN, 8'hF0);
    wr(ADDR_STATUS, 8'h04);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_DATA_LO, 8'h00);
      wait_idle(16);
    end
    rd(ADDR_STATUS, 8'h44);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_COUNT, 8'h00);
    rd(ADDR_CHAN, CHAN_RST);
    wr(ADDR_DATA_LO, 8'h00);
    wait_idle(1);
    rd_sample(4'h0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_single();
    t_scan();
    t_irq();
    t_irq_scan();
    t_overflow();
    t_hw_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
